// ===== bus_event_count_select.sv
// Steers observed bus events to the four bus counters and the WCB counter
`timescale 1ns/100ps
`include "fsb_evtsel_consts.svh"
// Functional notes
// R1: Select 16H with counter select 3 counts back-to-back cycles, mask bits 1-6.
// R2: Select 08H with counter select 3 counts bus-not-ready, mask bits 0-2.
// R3: Select 06H with counter select 3 counts snoop hit modified, bits 2,6,7.
// R4: Response event needs counter select 3; mask bits 1,2,8,9 choose types.
// R5: WCB event uses counter select 5; full evictions flag doubtful alias counts.
// R6: Back-to-back, not-ready and snoop may be absent; then they count zero.
// R7: WCB mask bit 0 any-cause evictions, bit 1 no-free-buffer evictions.
// R8: Selector A feeds only counters 0 and 1, selector B only 2 and 3.
module bus_event_count_select (
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      resetn_i,
    // Register port
    input  wire fsb_evtsel_pkg::reg_req_s  reg_req_i,
    output logic [31:0]                    reg_rdata_o,
    // Observed bus traffic, same clock domain
    input  wire fsb_evtsel_pkg::bus_obs_s  bus_obs_i,
    // Increment pulses to the counters
    output logic [3:0]                     cnt_inc_o,
    output logic                           wcb_inc_o
);

    fsb_evtsel_pkg::evtsel_state_s st_ff;
    fsb_evtsel_pkg::evtsel_state_s nxt_st;

    // Optional events carried by this model; a cleared bit makes the
    // event decode to nothing rather than count stray traffic
    localparam logic [2:0] EVT_SUP = `EVT_SUPPORT;

    logic                           hit_a;
    logic                           hit_b;
    logic                           wcb_hit;
    logic                           wcb_full_seen;
    logic [3:0]                     cnt_fire;

    // ======================================================================
    // Event decode

    // One selector word against the observed traffic; unsupported events
    // decode to nothing so software simply sees a zero count
    function automatic logic sel_hit(
        input logic [31:0]              sel,
        input fsb_evtsel_pkg::bus_obs_s obs
    );
        logic [5:0]  es;
        logic [15:0] m;
        logic        h;
        es = sel[`ES_HI:`ES_LO];
        m  = sel[`MASK_HI:`MASK_LO];
        h  = 1'b0;
        case (es)
            `ES_B2B: begin
                h = EVT_SUP[0] && |(obs.b2b & m & `MASK_B2B); // R1 R6
            end
            `ES_BNR: begin
                h = EVT_SUP[1] && |(obs.bnr & m & `MASK_BNR); // R2 R6
            end
            `ES_SNOOP: begin
                h = EVT_SUP[2]
                    && |(obs.snoop & m & `MASK_SNOOP); // R3 R6
            end
            `ES_RESP: begin
                h = |(obs.resp & m & `MASK_RESP); // R4
            end
            default: begin
                h = 1'b0;
            end
        endcase
        return h;
    endfunction

    // Both bus selectors are decoded every cycle
    assign hit_a = sel_hit(st_ff.sel_a, bus_obs_i);
    assign hit_b = sel_hit(st_ff.sel_b, bus_obs_i);

    // Counter routing is fixed, so a misprogrammed counter stays silent
    // rather than picking up the other selector's traffic
    always_comb begin
        for (int i = 0; i < `NUM_CNT; i++) begin
            cnt_fire[i] = st_ff.cfg[i][`CFG_EN_BIT]
                && (st_ff.cfg[i][`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_FSB)
                && ((i < `CNT_PER_SEL) ? hit_a : hit_b); // R8 R1 R2 R3 R4
        end
    end

    // Write-combining buffer evictions
    assign wcb_hit = st_ff.wcb_cfg[`CFG_EN_BIT]
        && (st_ff.wcb_cfg[`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_WCB) // R5
        && (st_ff.wcb_sel[`ES_HI:`ES_LO] == `ES_WCB)
        && |(bus_obs_i.wcb & st_ff.wcb_sel[`MASK_HI:`MASK_LO]
             & `MASK_WCB); // R7

    // A full eviction while the WCB count runs makes alias counts doubtful
    assign wcb_full_seen = wcb_hit
        && bus_obs_i.wcb[`WCB_FULL_BIT]; // R5

    // ======================================================================
    // Next state: register writes, reads, sticky status, pulses
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rdata   = `RESET_WORD;
        nxt_st.cnt_inc = cnt_fire;
        nxt_st.wcb_inc = wcb_hit;
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `OFS_SEL_A: begin
                    nxt_st.sel_a = reg_req_i.wdata;
                end
                `OFS_SEL_B: begin
                    nxt_st.sel_b = reg_req_i.wdata;
                end
                `OFS_WCB_SEL: begin
                    nxt_st.wcb_sel = reg_req_i.wdata;
                end
                `OFS_CFG0: begin
                    nxt_st.cfg[0] = reg_req_i.wdata;
                end
                `OFS_CFG1: begin
                    nxt_st.cfg[1] = reg_req_i.wdata;
                end
                `OFS_CFG2: begin
                    nxt_st.cfg[2] = reg_req_i.wdata;
                end
                `OFS_CFG3: begin
                    nxt_st.cfg[3] = reg_req_i.wdata;
                end
                `OFS_WCB_CFG: begin
                    nxt_st.wcb_cfg = reg_req_i.wdata;
                end
                `OFS_STATUS: begin
                    // Write one to clear
                    nxt_st.status = st_ff.status & ~reg_req_i.wdata[4:0];
                end
                default: begin
                    nxt_st.status = st_ff.status;
                end
            endcase
        end
        // Set after clear so a same-cycle event is never lost
        nxt_st.status[3:0] = nxt_st.status[3:0] | cnt_fire;
        nxt_st.status[`STAT_ALIAS_BIT] = nxt_st.status[`STAT_ALIAS_BIT]
            | wcb_full_seen; // R5
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `OFS_SEL_A: begin
                    nxt_st.rdata = st_ff.sel_a;
                end
                `OFS_SEL_B: begin
                    nxt_st.rdata = st_ff.sel_b;
                end
                `OFS_WCB_SEL: begin
                    nxt_st.rdata = st_ff.wcb_sel;
                end
                `OFS_CFG0: begin
                    nxt_st.rdata = st_ff.cfg[0];
                end
                `OFS_CFG1: begin
                    nxt_st.rdata = st_ff.cfg[1];
                end
                `OFS_CFG2: begin
                    nxt_st.rdata = st_ff.cfg[2];
                end
                `OFS_CFG3: begin
                    nxt_st.rdata = st_ff.cfg[3];
                end
                `OFS_WCB_CFG: begin
                    nxt_st.rdata = st_ff.wcb_cfg;
                end
                `OFS_STATUS: begin
                    nxt_st.rdata = {27'h0000000, st_ff.status};
                end
                `OFS_CAPS: begin
                    nxt_st.rdata = {29'h0000000, EVT_SUP}; // R6
                end
                default: begin
                    nxt_st.rdata = `RESET_WORD;
                end
            endcase
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff.sel_a   <= `RESET_WORD;
            st_ff.sel_b   <= `RESET_WORD;
            st_ff.wcb_sel <= `RESET_WORD;
            st_ff.cfg     <= {4{`RESET_WORD}};
            st_ff.wcb_cfg <= `RESET_WORD;
            st_ff.status  <= `RESET_STAT;
            st_ff.rdata   <= `RESET_WORD;
            st_ff.cnt_inc <= 4'h0;
            st_ff.wcb_inc <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o = st_ff.rdata;
    assign cnt_inc_o   = st_ff.cnt_inc;
    assign wcb_inc_o   = st_ff.wcb_inc;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_b2b_count: assert property ( // R1
        (EVT_SUP[0]
         && st_ff.sel_a[`ES_HI:`ES_LO] == `ES_B2B
         && st_ff.cfg[0][`CFG_EN_BIT]
         && st_ff.cfg[0][`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_FSB
         && |(bus_obs_i.b2b & st_ff.sel_a[`MASK_HI:`MASK_LO] & `MASK_B2B))
        |=> cnt_inc_o[0])
        else $error("back-to-back cycle not counted");

    a_bnr_mask_limit: assert property ( // R2
        (st_ff.sel_a[`ES_HI:`ES_LO] == `ES_BNR
         && ~|(bus_obs_i.bnr & `MASK_BNR))
        |=> !cnt_inc_o[0] && !cnt_inc_o[1])
        else $error("not-ready counted without a legal sub-event");

    a_snoop_count: assert property ( // R3
        (EVT_SUP[2]
         && st_ff.sel_b[`ES_HI:`ES_LO] == `ES_SNOOP
         && st_ff.cfg[2][`CFG_EN_BIT]
         && st_ff.cfg[2][`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_FSB
         && |(bus_obs_i.snoop & st_ff.sel_b[`MASK_HI:`MASK_LO]
              & `MASK_SNOOP))
        |=> cnt_inc_o[2])
        else $error("snoop hit modified not counted");

    a_resp_csel: assert property ( // R4
        cnt_inc_o[3]
        |-> $past(st_ff.cfg[3][`CFG_SEL_HI:`CFG_SEL_LO]) == `CSEL_FSB)
        else $error("bus counter fired without counter select 3");

    a_wcb_csel: assert property ( // R5
        wcb_inc_o
        |-> $past(st_ff.wcb_cfg[`CFG_SEL_HI:`CFG_SEL_LO]) == `CSEL_WCB
            && $past(st_ff.wcb_sel[`ES_HI:`ES_LO]) == `ES_WCB)
        else $error("WCB pulse without WCB selection");

    a_caps_report: assert property ( // R6
        (reg_req_i.rd && reg_req_i.addr == `OFS_CAPS)
        |=> reg_rdata_o == {29'h0000000, EVT_SUP})
        else $error("support mask not reported");

    a_wcb_full_flag: assert property ( // R7
        (wcb_hit && bus_obs_i.wcb[`WCB_FULL_BIT])
        |=> wcb_inc_o && st_ff.status[`STAT_ALIAS_BIT])
        else $error("no-free-buffer eviction lost");

    a_route_a: assert property ( // R8
        (cnt_inc_o[0] || cnt_inc_o[1]) |-> $past(hit_a))
        else $error("counter 0 or 1 fired without selector A");

    a_route_b: assert property ( // R8
        (cnt_inc_o[2] || cnt_inc_o[3]) |-> $past(hit_b))
        else $error("counter 2 or 3 fired without selector B");

    a_read_once: assert property (
        !reg_req_i.rd ##1 1'b1 |-> reg_rdata_o == `RESET_WORD)
        else $error("read data stands outside its cycle");

    // Positive counts for the events not covered above
    a_bnr_count: assert property ( // R2
        (EVT_SUP[1]
         && st_ff.sel_b[`ES_HI:`ES_LO] == `ES_BNR
         && st_ff.cfg[3][`CFG_EN_BIT]
         && st_ff.cfg[3][`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_FSB
         && |(bus_obs_i.bnr & st_ff.sel_b[`MASK_HI:`MASK_LO] & `MASK_BNR))
        |=> cnt_inc_o[3])
        else $error("bus-not-ready condition not counted");

    a_resp_count: assert property ( // R4
        (st_ff.sel_a[`ES_HI:`ES_LO] == `ES_RESP
         && st_ff.cfg[0][`CFG_EN_BIT]
         && st_ff.cfg[0][`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_FSB
         && |(bus_obs_i.resp & st_ff.sel_a[`MASK_HI:`MASK_LO] & `MASK_RESP))
        |=> cnt_inc_o[0])
        else $error("bus response not counted");

    a_wcb_any_count: assert property ( // R7
        (st_ff.wcb_cfg[`CFG_EN_BIT]
         && st_ff.wcb_cfg[`CFG_SEL_HI:`CFG_SEL_LO] == `CSEL_WCB
         && st_ff.wcb_sel[`ES_HI:`ES_LO] == `ES_WCB
         && st_ff.wcb_sel[`MASK_LO + `WCB_ANY_BIT]
         && bus_obs_i.wcb[`WCB_ANY_BIT])
        |=> wcb_inc_o)
        else $error("any-cause eviction not counted");

    // Sticky status: a hit always lands, even beside a clear
    a_hit_sticky: assert property (
        cnt_fire[0] |=> st_ff.status[0])
        else $error("counter hit not recorded in status");

    a_status_clear: assert property (
        (reg_req_i.wr && reg_req_i.addr == `OFS_STATUS
         && reg_req_i.wdata[0] && !cnt_fire[0])
        |=> !st_ff.status[0])
        else $error("status bit survived write one to clear");

endmodule

// ===== fsb_evtsel_consts.svh
// Constants for the bus event selection block: offsets, fields, codes
`ifndef FSB_EVTSEL_CONSTS_SVH
`define FSB_EVTSEL_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses on the plain register port)
`define OFS_SEL_A        8'h00
`define OFS_SEL_B        8'h04
`define OFS_WCB_SEL      8'h08
`define OFS_CFG0         8'h0C
`define OFS_CFG1         8'h10
`define OFS_CFG2         8'h14
`define OFS_CFG3         8'h18
`define OFS_WCB_CFG      8'h1C
`define OFS_STATUS       8'h20
`define OFS_CAPS         8'h24

// ==========================================================================
// Field positions
`define ES_HI            30
`define ES_LO            25
`define MASK_HI          24
`define MASK_LO          9
`define CFG_SEL_HI       15
`define CFG_SEL_LO       13
`define CFG_EN_BIT       12

// ==========================================================================
// Event select and counter select codes
`define ES_B2B           6'h16
`define ES_BNR           6'h08
`define ES_SNOOP         6'h06
`define ES_RESP          6'h04
`define ES_WCB           6'h05
`define CSEL_FSB         3'h3
`define CSEL_WCB         3'h5

// ==========================================================================
// Legal sub-event masks per event
`define MASK_B2B         16'h007E
`define MASK_BNR         16'h0007
`define MASK_SNOOP       16'h00C4
`define MASK_RESP        16'h0306
`define MASK_WCB         16'h0003
`define WCB_ANY_BIT      0
`define WCB_FULL_BIT     1

// ==========================================================================
// Model support: bit 0 back-to-back, bit 1 not-ready, bit 2 snoop
`define EVT_SUPPORT      3'h7
`define NUM_CNT          4
`define CNT_PER_SEL      2
`define STAT_ALIAS_BIT   4
`define RESET_WORD       32'h0000_0000
`define RESET_STAT       5'h00

`endif

// ===== fsb_evtsel_pkg.sv
// Types shared by the bus event selection block
package fsb_evtsel_pkg;

    // Observed bus occurrences, one bit per sub-event mask position
    typedef struct packed {
        logic [15:0] b2b;
        logic [15:0] bnr;
        logic [15:0] snoop;
        logic [15:0] resp;
        logic [15:0] wcb;
    } bus_obs_s;

    // One register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    // Whole state of the block
    typedef struct packed {
        logic [31:0]       sel_a;
        logic [31:0]       sel_b;
        logic [31:0]       wcb_sel;
        logic [3:0][31:0]  cfg;
        logic [31:0]       wcb_cfg;
        logic [4:0]        status;
        logic [31:0]       rdata;
        logic [3:0]        cnt_inc;
        logic              wcb_inc;
    } evtsel_state_s;

endpackage

// ===== bus_obs_gen.sv
// Bus agent model: raises one observed sub-event bit for one cycle, or wcb bits 0 and 1 for a no-free-buffer eviction
`timescale 1ns/100ps
module bus_obs_gen (
    // Clock
    input  wire logic                 clk_sys_i,
    // Request from the bench
    input  wire logic                 fire_i,
    input  wire logic [2:0]           field_i,
    input  wire logic [3:0]           bit_i,
    // Observed traffic
    output fsb_evtsel_pkg::bus_obs_s  obs_o
);
    fsb_evtsel_pkg::bus_obs_s nxt_obs;
    initial obs_o = '0;
    // ==========================================================
    // One bus occurrence per request; idle traffic shows nothing
    always @(posedge clk_sys_i) begin
        nxt_obs = '0;
        if (fire_i) begin
            case (field_i)
                3'h0: nxt_obs.b2b[bit_i] = 1'b1;
                3'h1: nxt_obs.bnr[bit_i] = 1'b1;
                3'h2: nxt_obs.snoop[bit_i] = 1'b1;
                3'h3: nxt_obs.resp[bit_i] = 1'b1;
                default: nxt_obs.wcb[bit_i] = 1'b1;
            endcase
            // A no-free-buffer eviction is an eviction too
            if (field_i == 3'h4 && bit_i == 4'h1) begin
                nxt_obs.wcb[0] = 1'b1;
            end
        end
        obs_o <= nxt_obs;
    end
endmodule

// ===== tb.sv
// Self-checking bench for the bus event selection block
`timescale 1ns/100ps
`include "fsb_evtsel_consts.svh"
module tb;
    logic                      clk_sys_i = 1'b0;
    logic                      resetn_i  = 1'b0;
    fsb_evtsel_pkg::reg_req_s  req       = '0;
    fsb_evtsel_pkg::bus_obs_s  obs;
    logic [31:0]               reg_rdata_o;
    logic [3:0]                cnt_inc_o;
    logic                      wcb_inc_o;
    logic                      fire      = 1'b0;
    logic [2:0]                fld       = 3'h0;
    logic [3:0]                bitn      = 4'h0;
    int                        bad_count = 0;
    int                        n_compared = 0;

    bus_event_count_select uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .reg_req_i(req), .reg_rdata_o(reg_rdata_o), .bus_obs_i(obs),
        .cnt_inc_o(cnt_inc_o), .wcb_inc_o(wcb_inc_o));
    bus_obs_gen agent (.clk_sys_i(clk_sys_i), .fire_i(fire),
        .field_i(fld), .bit_i(bitn), .obs_o(obs));

    // ==========================================================
    // Clock, 8 ns period
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ==========================================================
    // Register port master, one-cycle strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata_o);
    endtask

    function automatic logic [31:0] selw(logic [5:0] es, logic [15:0] m);
        return {1'b0, es, m, 9'h000};
    endfunction
    function automatic logic [31:0] cfgw(logic [2:0] s);
        return {16'h0000, s, 1'b1, 12'h000};
    endfunction

    // One bus occurrence, then the pulse and its end are judged
    task automatic pulse(input logic [2:0] f, input logic [3:0] b,
                         input logic [3:0] ec, input logic ew);
        @(posedge clk_sys_i);
        fire <= 1'b1;
        fld  <= f;
        bitn <= b;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk("inc", {27'h0, ew, ec}, {27'h0, wcb_inc_o, cnt_inc_o});
        @(posedge clk_sys_i);
        #1;
        chk("inc_end", 32'h0, {27'h0, wcb_inc_o, cnt_inc_o});
    endtask

    // ==========================================================
    // Tests
    task automatic t_regs();
        rd(`OFS_CAPS, 32'h7, "caps");
        wr(`OFS_CAPS, 32'h0);
        rd(`OFS_CAPS, 32'h7, "caps_ro");
        rd(8'h40, 32'h0, "unmapped");
        rd(`OFS_STATUS, 32'h0, "status_rst");
        $display("test regs done");
    endtask

    task automatic t_events();
        logic [5:0] es [4];
        logic [3:0] good [4];
        logic [3:0] bad [4];
        es   = '{`ES_B2B, `ES_BNR, `ES_SNOOP, `ES_RESP};
        good = '{4'h1, 4'h2, 4'h7, 4'h9};
        bad  = '{4'h0, 4'h3, 4'h3, 4'hA};
        wr(`OFS_CFG0, cfgw(`CSEL_FSB));
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_SEL_A, selw(es[i], 16'hFFFF));
            pulse(3'(i), good[i], 4'h1, 1'b0);
            pulse(3'(i), bad[i], 4'h0, 1'b0);
            pulse(3'((i + 1) % 4), good[(i + 1) % 4], 4'h0, 1'b0);
        end
        wr(`OFS_SEL_A, selw(`ES_B2B, 16'h0002));
        pulse(3'h0, 4'h2, 4'h0, 1'b0);
        pulse(3'h0, 4'h6, 4'h0, 1'b0);
        wr(`OFS_CFG0, cfgw(3'h2));
        pulse(3'h0, 4'h1, 4'h0, 1'b0);
        rd(`OFS_STATUS, 32'h01, "status_hit");
        wr(`OFS_STATUS, 32'h1F);
        rd(`OFS_STATUS, 32'h00, "status_clr");
        $display("test events done");
    endtask

    task automatic t_route();
        wr(`OFS_SEL_A, 32'h0);
        wr(`OFS_SEL_B, selw(`ES_BNR, 16'h0007));
        rd(`OFS_SEL_B, selw(`ES_BNR, 16'h0007), "sel_b");
        for (int i = 0; i < 4; i++) begin
            wr(8'(`OFS_CFG0 + 4 * i), cfgw(`CSEL_FSB));
            rd(8'(`OFS_CFG0 + 4 * i), cfgw(`CSEL_FSB), "cfg");
        end
        pulse(3'h1, 4'h0, 4'hC, 1'b0);
        wr(`OFS_SEL_A, selw(`ES_SNOOP, 16'h00C4));
        rd(`OFS_SEL_A, selw(`ES_SNOOP, 16'h00C4), "sel_a");
        pulse(3'h2, 4'h6, 4'h3, 1'b0);
        wr(`OFS_SEL_B, selw(`ES_SNOOP, 16'h0004));
        pulse(3'h2, 4'h2, 4'hF, 1'b0);
        rd(`OFS_STATUS, 32'h0F, "status_route");
        wr(`OFS_STATUS, 32'h1F);
        $display("test route done");
    endtask

    task automatic t_wcb();
        wr(`OFS_WCB_SEL, selw(`ES_WCB, 16'h0002));
        wr(`OFS_WCB_CFG, cfgw(`CSEL_FSB));
        pulse(3'h4, 4'h1, 4'h0, 1'b0);
        wr(`OFS_WCB_CFG, cfgw(`CSEL_WCB));
        rd(`OFS_WCB_CFG, cfgw(`CSEL_WCB), "wcb_cfg");
        pulse(3'h4, 4'h0, 4'h0, 1'b0);
        pulse(3'h4, 4'h1, 4'h0, 1'b1);
        rd(`OFS_STATUS, 32'h10, "status_full");
        wr(`OFS_WCB_SEL, selw(`ES_WCB, 16'h0001));
        rd(`OFS_WCB_SEL, selw(`ES_WCB, 16'h0001), "wcb_sel");
        pulse(3'h4, 4'h0, 4'h0, 1'b1);
        pulse(3'h4, 4'h1, 4'h0, 1'b1);
        $display("test wcb done");
    endtask

    // Reset in mid-run, then selector A, WCB config and status read back as zero; first read right after
    task automatic t_reset();
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rd(`OFS_SEL_A, 32'h0, "sel_a_rst");
        rd(`OFS_WCB_CFG, 32'h0, "wcb_cfg_rst");
        rd(`OFS_STATUS, 32'h0, "status_rst2");
        $display("test reset done");
    endtask

    // ==========================================================
    // Verdict
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        t_regs();
        t_events();
        t_route();
        t_wcb();
        t_reset();
        end_of_test();
    end
endmodule
